// *** pkg/mfr_cfg.svh ***
// constants for the mac filter and retry control block
// assumes inclusion by bare name from the design modules
// What this block does
// - hash-only bit 15 set hashes both individual and multicast addresses
// - select bit 13 clear with hash-only clear filters by exact station address match
// - select bit 13 set hash-filters multicast destinations
// - select set: individual hashed if hash-only, else exact match
// - late-collision bit 12 set retries late collisions, clear abandons the frame
// - late collision always recorded in transmit status
// - broadcast-reject bit 11 set drops broadcasts, clear forwards them
// - retry-disable bit 10 set: one attempt, drop on collision, flag retry error
// - retry-disable clear: up to 16 attempts before retry error
// - pad-strip bit 8 set strips pad and fcs when length below 46
// - with pad-strip, length 46 or more delivered unaltered with fcs
// - pad-strip clear passes every frame unmodified
// - backoff bounded by two to the K, K is min of retries and 10
// - backoff value from free-running 20-bit lfsr
// - K low lfsr bits count down per slot, retry at zero
// - backoff-limit field bits 7-6 caps number of lfsr bits used, bits used is min of K and limit
// - limit 00 gives 10 bits, 01 8, 10 4, 11 1
// - destination first bit one marks multicast
`ifndef MFR_CFG_SVH
`define MFR_CFG_SVH
`define MFR_IDX_CTRL 3'h1
`define MFR_IDX_STAT 3'h2
`define MFR_IDX_SA_LO 3'h3
`define MFR_IDX_SA_HI 3'h4
`define MFR_B_HO 15
`define MFR_B_HPS 13
`define MFR_B_LCR 12
`define MFR_B_BCR 11
`define MFR_B_RDIS 10
`define MFR_B_PAD 8
`define MFR_B_BOL 7:6
`define MFR_B_RSV_HI 14
`define MFR_B_RSV_LO 9
`define MFR_CTRL_WMASK 32'h0000_bdc0
`define MFR_CTRL_RST 32'h0000_0000
`define MFR_S_LATE 0
`define MFR_S_RERR 1
`define MFR_S_BUSY 2
`define MFR_S_ATT 8:4
`define MFR_S_RXA 16
`define MFR_S_RXS 17
`define MFR_MIN_LEN 16'h002e
`define MFR_MAX_ATT 5'h10
`define MFR_K_CAP 4'ha
`define MFR_BOL_00 4'ha
`define MFR_BOL_01 4'h8
`define MFR_BOL_10 4'h4
`define MFR_BOL_11 4'h1
`define MFR_LFSR_SEED 20'h00001
`define MFR_LFSR_TAPS 20'h90000
`define MFR_MC_BIT 40
`define MFR_BROADCAST_REJECT_ADDR 48'hffff_ffff_ffff
`endif

// *** pkg/mfr_pkg.sv ***
// types shared by the filter and retry control modules
// assumes nothing beyond a standard compile order
`default_nettype none
package mfr_pkg;
   typedef enum logic [0:0] {MFR_TX_IDLE, MFR_TX_WAIT} mfr_tx_state_t;
   typedef logic [3:0] mfr_nbits_t;
   typedef logic [9:0] mfr_count_t;
endpackage : mfr_pkg
`default_nettype wire

// *** pkg/mfr_bo_if.sv ***
// link between the retry controller and the backoff counter
// assumes one clock shared by both ends
`default_nettype none
interface mfr_bo_if;
   import mfr_pkg::*;
   logic load;
   mfr_nbits_t nbits;
   logic tick;
   logic busy;
   logic expire;
   modport ctl (output load, output nbits, output tick, input busy, input expire);
   modport bo (input load, input nbits, input tick, output busy, output expire);
endinterface : mfr_bo_if
`default_nettype wire

// *** src/mfr_backoff.sv ***
// backoff counter fed by a free-running lfsr
// assumes load and tick come from the retry controller on ref_clk
`default_nettype none
`include "mfr_cfg.svh"
module mfr_backoff
   import mfr_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // controller side
   mfr_bo_if.bo bo
);
   logic [19:0] lfsr;
   logic [19:0] next_lfsr;
   mfr_count_t count;
   mfr_count_t next_count;
   logic busy;
   logic next_busy;
   logic expire;
   logic next_expire;

   function automatic mfr_count_t bo_mask(input mfr_nbits_t n);
      logic [10:0] m;
      m = (11'h001 << n) - 11'h001;
      return m[9:0];
   endfunction : bo_mask

   always_comb begin
      next_lfsr = {lfsr[18:0], ^(lfsr & `MFR_LFSR_TAPS)};
      next_count = count;
      next_busy = busy;
      next_expire = 1'b0;
      if (bo.load) begin
         next_count = lfsr[9:0] & bo_mask(bo.nbits);
         next_busy = 1'b1;
      end else if (busy && count == 10'h000) begin
         next_busy = 1'b0;
         next_expire = 1'b1;
      end else if (busy && bo.tick) begin
         next_count = count - 10'h001;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         lfsr <= `MFR_LFSR_SEED;
         count <= 10'h000;
         busy <= 1'b0;
         expire <= 1'b0;
      end else begin
         lfsr <= next_lfsr;
         count <= next_count;
         busy <= next_busy;
         expire <= next_expire;
      end
   end

   assign bo.busy = busy;
   assign bo.expire = expire;

   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   AST_BO_RANGE: assert property (bo.load |=> count <= $past(bo_mask(bo.nbits)))
      else $error("backoff count exceeds selected width");
   AST_BO_EXPIRE: assert property (busy && count == 10'h000 && !bo.load |=> expire && !busy)
      else $error("backoff did not expire at zero");
   AST_LFSR_LIVE: assert property (lfsr != 20'h00000)
      else $error("lfsr locked at zero");
endmodule : mfr_backoff
`default_nettype wire

// *** src/mfr_top.sv ***
// mac address filter, pad strip and transmit retry control
// assumes avalon-mm master on ref_clk, rx and tx events synchronous
`default_nettype none
`include "mfr_cfg.svh"
module mfr_top
   import mfr_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // avalon-mm slave
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // receive frame header
   input wire logic rx_frame_valid,
   input wire logic [47:0] rx_dest_addr,
   input wire logic rx_hash_hit,
   input wire logic [15:0] rx_length_field,
   // receive decision
   output logic rx_result_valid,
   output logic rx_accept,
   output logic rx_strip,
   // transmit events
   input wire logic tx_collision,
   input wire logic tx_late,
   input wire logic tx_frame_done,
   input wire logic slot_tick,
   // transmit decision
   output logic tx_retry_go,
   output logic tx_abandon,
   output logic tx_status_late,
   output logic tx_status_retry_err
);
   mfr_bo_if bo_link ();

   mfr_backoff u_backoff (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .bo(bo_link.bo)
   );

   function automatic logic is_reg(input logic [4:0] a, input logic [2:0] idx);
      return a[4:2] == idx;
   endfunction : is_reg

   // register bus state
   logic [31:0] ctrl;
   logic [31:0] next_ctrl;
   logic [47:0] station_addr;
   logic [47:0] next_station_addr;
   logic [31:0] next_readdata;
   logic next_waitrequest;
   logic [31:0] rd_mux;
   logic wr_go;
   logic [1:0] w1c;

   // control fields
   logic hash_only_filter;
   logic hash_perfect_select;
   logic late_collision_retry;
   logic broadcast_reject;
   logic retry_disable;
   logic pad_strip_enable;
   logic [1:0] backoff_limit;

   assign hash_only_filter = ctrl[`MFR_B_HO];
   assign hash_perfect_select = ctrl[`MFR_B_HPS];
   assign late_collision_retry = ctrl[`MFR_B_LCR];
   assign broadcast_reject = ctrl[`MFR_B_BCR];
   assign retry_disable = ctrl[`MFR_B_RDIS];
   assign pad_strip_enable = ctrl[`MFR_B_PAD];
   assign backoff_limit = ctrl[`MFR_B_BOL];

   // transmit state
   mfr_tx_state_t tx_state;
   mfr_tx_state_t next_tx_state;
   logic [4:0] attempts;
   logic [4:0] next_attempts;
   logic next_retry_go;
   logic next_abandon;
   logic next_late;
   logic next_retry_err;
   logic bo_load;
   logic next_bo_load;
   mfr_nbits_t bo_nbits;
   mfr_nbits_t next_bo_nbits;

   // receive state
   logic next_rx_valid;
   logic next_rx_accept;
   logic next_rx_strip;

   assign wr_go = avs_write && !avs_waitrequest;

   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (avs_address[4:2])
         `MFR_IDX_CTRL: rd_mux = ctrl;
         `MFR_IDX_STAT: begin
            rd_mux[`MFR_S_LATE] = tx_status_late;
            rd_mux[`MFR_S_RERR] = tx_status_retry_err;
            rd_mux[`MFR_S_BUSY] = bo_link.busy;
            rd_mux[`MFR_S_ATT] = attempts;
            rd_mux[`MFR_S_RXA] = rx_accept;
            rd_mux[`MFR_S_RXS] = rx_strip;
         end
         `MFR_IDX_SA_LO: rd_mux = station_addr[31:0];
         `MFR_IDX_SA_HI: rd_mux = {16'h0000, station_addr[47:32]};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always_comb begin
      next_waitrequest = 1'b1;
      next_readdata = avs_readdata;
      next_ctrl = ctrl;
      next_station_addr = station_addr;
      w1c = 2'h0;
      if ((avs_read || avs_write) && avs_waitrequest) begin
         next_waitrequest = 1'b0;
         if (avs_read) begin
            next_readdata = rd_mux;
         end
      end
      if (wr_go && is_reg(avs_address, `MFR_IDX_CTRL)) begin
         next_ctrl = avs_writedata & `MFR_CTRL_WMASK;
      end
      if (wr_go && is_reg(avs_address, `MFR_IDX_SA_LO)) begin
         next_station_addr[31:0] = avs_writedata;
      end
      if (wr_go && is_reg(avs_address, `MFR_IDX_SA_HI)) begin
         next_station_addr[47:32] = avs_writedata[15:0];
      end
      if (wr_go && is_reg(avs_address, `MFR_IDX_STAT)) begin
         w1c = {avs_writedata[`MFR_S_RERR], avs_writedata[`MFR_S_LATE]};
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         ctrl <= `MFR_CTRL_RST;
         station_addr <= 48'h0000_0000_0000;
         avs_readdata <= 32'h0000_0000;
         avs_waitrequest <= 1'b1;
      end else begin
         ctrl <= next_ctrl;
         station_addr <= next_station_addr;
         avs_readdata <= next_readdata;
         avs_waitrequest <= next_waitrequest;
      end
   end

   // receive address filter and pad strip
   logic is_broadcast_reject;
   logic is_mcast;
   logic exact_hit;

   always_comb begin
      is_broadcast_reject = rx_dest_addr == `MFR_BROADCAST_REJECT_ADDR;
      is_mcast = rx_dest_addr[`MFR_MC_BIT];
      exact_hit = rx_dest_addr == station_addr;
      next_rx_valid = rx_frame_valid;
      next_rx_accept = rx_accept;
      next_rx_strip = rx_strip;
      if (rx_frame_valid) begin
         if (is_broadcast_reject) begin
            next_rx_accept = !broadcast_reject;
         end else if (is_mcast) begin
            next_rx_accept = (hash_perfect_select || hash_only_filter) ? rx_hash_hit : exact_hit;
         end else begin
            next_rx_accept = hash_only_filter ? rx_hash_hit : exact_hit;
         end
         next_rx_strip = pad_strip_enable && (rx_length_field < `MFR_MIN_LEN);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         rx_result_valid <= 1'b0;
         rx_accept <= 1'b0;
         rx_strip <= 1'b0;
      end else begin
         rx_result_valid <= next_rx_valid;
         rx_accept <= next_rx_accept;
         rx_strip <= next_rx_strip;
      end
   end

   // transmit retry and backoff control
   logic [4:0] att_inc;
   mfr_nbits_t k_exp;
   mfr_nbits_t lim_bits;

   always_comb begin
      att_inc = attempts + 5'h01;
      // K is retries capped at ten
      k_exp = (att_inc > {1'b0, `MFR_K_CAP}) ? `MFR_K_CAP : att_inc[3:0];
      unique case (backoff_limit)
         2'h0: lim_bits = `MFR_BOL_00;
         2'h1: lim_bits = `MFR_BOL_01;
         2'h2: lim_bits = `MFR_BOL_10;
         2'h3: lim_bits = `MFR_BOL_11;
      endcase
      next_tx_state = tx_state;
      next_attempts = attempts;
      next_retry_go = 1'b0;
      next_abandon = 1'b0;
      next_bo_load = 1'b0;
      next_bo_nbits = bo_nbits;
      next_late = tx_status_late & ~w1c[0];
      next_retry_err = tx_status_retry_err & ~w1c[1];
      if (tx_frame_done) begin
         next_attempts = 5'h00;
      end
      unique case (tx_state)
         MFR_TX_IDLE: begin
            if (tx_collision) begin
               next_attempts = att_inc;
               if (tx_late) begin
                  next_late = 1'b1;
               end
               if (tx_late && !late_collision_retry) begin
                  next_abandon = 1'b1;
                  next_attempts = 5'h00;
               end else if (retry_disable || att_inc >= `MFR_MAX_ATT) begin
                  next_abandon = 1'b1;
                  next_retry_err = 1'b1;
                  next_attempts = 5'h00;
               end else begin
                  next_bo_load = 1'b1;
                  next_bo_nbits = (k_exp < lim_bits) ? k_exp : lim_bits;
                  next_tx_state = MFR_TX_WAIT;
               end
            end
         end
         MFR_TX_WAIT: begin
            if (bo_link.expire) begin
               next_retry_go = 1'b1;
               next_tx_state = MFR_TX_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         tx_state <= MFR_TX_IDLE;
         attempts <= 5'h00;
         tx_retry_go <= 1'b0;
         tx_abandon <= 1'b0;
         tx_status_late <= 1'b0;
         tx_status_retry_err <= 1'b0;
         bo_load <= 1'b0;
         bo_nbits <= 4'h0;
      end else begin
         tx_state <= next_tx_state;
         attempts <= next_attempts;
         tx_retry_go <= next_retry_go;
         tx_abandon <= next_abandon;
         tx_status_late <= next_late;
         tx_status_retry_err <= next_retry_err;
         bo_load <= next_bo_load;
         bo_nbits <= next_bo_nbits;
      end
   end

   assign bo_link.load = bo_load;
   assign bo_link.nbits = bo_nbits;
   assign bo_link.tick = slot_tick;

   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   sequence s_req_wait;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence

   sequence s_ack_once;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence

   sequence s_idle_coll;
      tx_state == MFR_TX_IDLE && tx_collision;
   endsequence

   sequence s_wait_done;
      tx_state == MFR_TX_WAIT && bo_link.expire;
   endsequence

   AST_BUS_ACK: assert property (s_req_wait |=> s_ack_once)
      else $error("bus request not answered in one cycle");
   AST_LATE_REC: assert property (s_idle_coll and tx_late |=> tx_status_late)
      else $error("late collision not recorded");
   AST_LATE_DROP: assert property (s_idle_coll and tx_late && !late_collision_retry
      |=> tx_abandon && tx_state == MFR_TX_IDLE)
      else $error("late collision not abandoned");
   AST_ONE_SHOT: assert property (s_idle_coll and !tx_late && retry_disable
      |=> tx_abandon && tx_status_retry_err)
      else $error("retry disable did not drop frame");
   AST_SIXTEEN: assert property (s_idle_coll and !tx_late && !retry_disable
      && attempts == 5'h0f |=> tx_abandon && tx_status_retry_err)
      else $error("sixteenth attempt not reported");
   AST_K_BOUND: assert property (bo_load |-> bo_nbits <= `MFR_K_CAP
      && bo_nbits <= attempts[3:0])
      else $error("backoff exponent out of bound");
   AST_LIMIT: assert property (bo_load |-> bo_nbits <= $past(lim_bits))
      else $error("backoff limit field ignored");
   AST_RETRY_GO: assert property (s_wait_done
      |=> tx_retry_go && tx_state == MFR_TX_IDLE)
      else $error("retry not granted after backoff");
   AST_BROADCAST_REJECT_REJ: assert property (rx_frame_valid && is_broadcast_reject && broadcast_reject
      |=> rx_result_valid && !rx_accept)
      else $error("broadcast frame not rejected");
   AST_BROADCAST_REJECT_PASS: assert property (rx_frame_valid && is_broadcast_reject && !broadcast_reject
      |=> rx_accept)
      else $error("broadcast frame not forwarded");
   AST_PERFECT: assert property (rx_frame_valid && !hash_perfect_select
      && !hash_only_filter && !is_broadcast_reject |=> rx_accept == $past(exact_hit))
      else $error("perfect filter mismatch");
   AST_HASH_ALL: assert property (rx_frame_valid && hash_only_filter && !is_broadcast_reject
      |=> rx_accept == $past(rx_hash_hit))
      else $error("hash only filter mismatch");
   AST_MC_HASH: assert property (rx_frame_valid && hash_perfect_select && is_mcast
      && !is_broadcast_reject |=> rx_accept == $past(rx_hash_hit))
      else $error("multicast hash filter mismatch");
   AST_IA_EXACT: assert property (rx_frame_valid && hash_perfect_select
      && !hash_only_filter && !is_mcast |=> rx_accept == $past(exact_hit))
      else $error("individual address not matched exactly");
   AST_PAD: assert property (rx_frame_valid |=> rx_strip == $past(pad_strip_enable
      && rx_length_field < `MFR_MIN_LEN))
      else $error("pad strip decision wrong");
   AST_RSV: assert property (ctrl[`MFR_B_RSV_HI] == 1'b0 && ctrl[`MFR_B_RSV_LO] == 1'b0)
      else $error("reserved control bit set");
endmodule : mfr_top
`default_nettype wire

// *** verif/mfr_phy_model.sv ***
// far side model: phy and remote station events seen by the filter and retry block
// assumes the bench calls its tasks and that all events follow ref_clk
`default_nettype none
module mfr_phy_model (
   // clock
   input wire logic ref_clk,
   // receive header
   output logic rx_frame_valid,
   output logic [47:0] rx_dest_addr,
   output logic rx_hash_hit,
   output logic [15:0] rx_length_field,
   // transmit events
   output logic tx_collision,
   output logic tx_late,
   output logic tx_frame_done,
   output logic slot_tick
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      rx_frame_valid = 1'b0;
      rx_dest_addr = '0;
      rx_hash_hit = 1'b0;
      rx_length_field = '0;
      tx_collision = 1'b0;
      tx_late = 1'b0;
      tx_frame_done = 1'b0;
      slot_tick = 1'b0;
   end

   // one slot time every two cycles
   always @(posedge ref_clk) begin
      slot_tick <= ~slot_tick;
   end

   // header fields are scrambled outside the valid cycle
   task automatic send_frame(input logic [47:0] da, input logic hit, input logic [15:0] len);
      @(posedge ref_clk);
      rx_frame_valid <= 1'b1;
      rx_dest_addr <= da;
      rx_hash_hit <= hit;
      rx_length_field <= len;
      @(posedge ref_clk);
      rx_frame_valid <= 1'b0;
      rx_dest_addr <= ~da;
      rx_hash_hit <= ~hit;
      rx_length_field <= ~len;
   endtask : send_frame

   task automatic collide(input logic late);
      @(posedge ref_clk);
      tx_collision <= 1'b1;
      tx_late <= late;
      @(posedge ref_clk);
      tx_collision <= 1'b0;
      tx_late <= ~late;
   endtask : collide

   task automatic frame_done();
      @(posedge ref_clk);
      tx_frame_done <= 1'b1;
      @(posedge ref_clk);
      tx_frame_done <= 1'b0;
   endtask : frame_done
endmodule : mfr_phy_model
`default_nettype wire

// *** verif/mfr_tb_top.sv ***
// self-checking bench for the filter and retry control block
// assumes the phy model drives every receive and transmit event
`default_nettype none
`include "mfr_cfg.svh"
module mfr_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk, reset_n, avs_read, avs_write, avs_waitrequest;
   logic [4:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic rx_frame_valid, rx_hash_hit, rx_result_valid, rx_accept, rx_strip;
   logic [47:0] rx_dest_addr;
   logic [15:0] rx_length_field;
   logic tx_collision, tx_late, tx_frame_done, slot_tick;
   logic tx_retry_go, tx_abandon, tx_status_late, tx_status_retry_err;
   int fail_count = 0;
   int n_compared = 0;
   logic [47:0] sa = 48'h0211_2233_4456;
   logic [47:0] da_tab [5] = '{48'hffff_ffff_ffff, 48'h0211_2233_4456,
      48'h0100_5e00_0001, 48'h0100_5e00_0001, 48'h0211_2233_4457};
   logic hit_tab [5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
   logic [15:0] len_tab [5] = '{16'h002d, 16'h002e, 16'h0000, 16'h0800, 16'h002d};
   int bits_tab [4] = '{10, 8, 4, 1};

   mfr_top i_dut (.ref_clk(ref_clk), .reset_n(reset_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .rx_frame_valid(rx_frame_valid), .rx_dest_addr(rx_dest_addr), .rx_hash_hit(rx_hash_hit),
      .rx_length_field(rx_length_field), .rx_result_valid(rx_result_valid),
      .rx_accept(rx_accept), .rx_strip(rx_strip), .tx_collision(tx_collision),
      .tx_late(tx_late), .tx_frame_done(tx_frame_done), .slot_tick(slot_tick),
      .tx_retry_go(tx_retry_go), .tx_abandon(tx_abandon), .tx_status_late(tx_status_late),
      .tx_status_retry_err(tx_status_retry_err));

   mfr_phy_model i_phy (.ref_clk(ref_clk), .rx_frame_valid(rx_frame_valid),
      .rx_dest_addr(rx_dest_addr), .rx_hash_hit(rx_hash_hit),
      .rx_length_field(rx_length_field), .tx_collision(tx_collision), .tx_late(tx_late),
      .tx_frame_done(tx_frame_done), .slot_tick(slot_tick));

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   task automatic close_out();
      $display("compared %0d wrong %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : close_out

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // holds the request until waitrequest is sampled low
   task automatic bus_wait();
      int n;
      n = 0;
      @(posedge ref_clk);
      while (avs_waitrequest !== 1'b0) begin
         n++;
         if (n > 50) begin
            fail_count++;
            close_out();
         end
         @(posedge ref_clk);
      end
   endtask : bus_wait

   task automatic bus_wr(input logic [2:0] idx, input logic [31:0] d);
      @(posedge ref_clk);
      avs_write <= 1'b1;
      avs_address <= {idx, 2'b00};
      avs_writedata <= d;
      bus_wait();
      avs_write <= 1'b0;
   endtask : bus_wr

   task automatic bus_rd(input logic [2:0] idx, output logic [31:0] d);
      @(posedge ref_clk);
      avs_read <= 1'b1;
      avs_address <= {idx, 2'b00};
      bus_wait();
      d = avs_readdata;
      avs_read <= 1'b0;
   endtask : bus_rd

   // result 1 retry granted, 2 frame dropped; counts slot ticks meanwhile
   task automatic tx_try(input logic late, output int res, output int ticks);
      ticks = 0;
      res = 0;
      i_phy.collide(late);
      for (int i = 0; i < 4000 && res == 0; i++) begin
         #1;
         if (tx_retry_go === 1'b1) res = 1;
         else if (tx_abandon === 1'b1) res = 2;
         else begin
            if (slot_tick === 1'b1) ticks++;
            @(posedge ref_clk);
         end
      end
      if (res == 0) begin
         fail_count++;
         close_out();
      end
   endtask : tx_try

   // c holds hash only, select, broadcast reject, pad strip
   function automatic logic exp_acc(input logic [3:0] c, input logic [47:0] da, input logic hit);
      if (da == `MFR_BROADCAST_REJECT_ADDR) return !c[1];
      if (da[`MFR_MC_BIT] && (c[3] || c[2])) return hit;
      if (!da[`MFR_MC_BIT] && c[3]) return hit;
      return da == sa;
   endfunction : exp_acc

   initial begin
      int res, ticks, k, maxt;
      logic [3:0] c;
      logic ea, es;
      reset_n = 1'b0;
      avs_address = '0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = '0;
      repeat (3) @(posedge ref_clk);
      reset_n <= 1'b1;
      bus_rd(`MFR_IDX_CTRL, rd);
      check("ctrl reset", rd, 32'h0000_0000);
      bus_wr(`MFR_IDX_CTRL, 32'hffff_ffff);
      bus_rd(`MFR_IDX_CTRL, rd);
      check("ctrl writable bits", rd, 32'h0000_bdc0);
      bus_wr(3'h7, 32'hffff_ffff);
      bus_rd(3'h7, rd);
      check("unmapped word", rd, 32'h0000_0000);
      bus_wr(`MFR_IDX_SA_LO, sa[31:0]);
      bus_wr(`MFR_IDX_SA_HI, {16'h0000, sa[47:32]});
      for (int ci = 0; ci < 16; ci++) begin
         c = ci[3:0];
         bus_wr(`MFR_IDX_CTRL, {16'h0, c[3], 1'b0, c[2], 1'b0, c[1], 2'b0, c[0], 8'h0});
         for (int f = 0; f < 5; f++) begin
            i_phy.send_frame(da_tab[f], hit_tab[f], len_tab[f]);
            #1;
            ea = exp_acc(c, da_tab[f], hit_tab[f]);
            es = c[0] && (len_tab[f] < 16'h002e);
            check("rx result valid", 32'(rx_result_valid), 32'h1);
            check("rx accept", 32'(rx_accept), 32'(ea));
            check("rx strip", 32'(rx_strip), 32'(es));
         end
      end
      bus_rd(`MFR_IDX_STAT, rd);
      check("status rx bits", {30'h0, rd[17:16]}, {30'h0, es, ea});
      bus_wr(`MFR_IDX_CTRL, 32'h0000_0400);
      i_phy.frame_done();
      tx_try(1'b0, res, ticks);
      check("single attempt drop", res, 2);
      check("retry error flag", 32'(tx_status_retry_err), 32'h1);
      bus_rd(`MFR_IDX_STAT, rd);
      check("status retry error", 32'(rd[1]), 32'h1);
      bus_wr(`MFR_IDX_STAT, 32'h0000_0003);
      bus_wr(`MFR_IDX_CTRL, 32'h0000_0000);
      check("status cleared", {30'h0, tx_status_late, tx_status_retry_err}, 32'h0);
      tx_try(1'b1, res, ticks);
      check("late collision drop", res, 2);
      check("late status", 32'(tx_status_late), 32'h1);
      bus_wr(`MFR_IDX_STAT, 32'h0000_0003);
      bus_wr(`MFR_IDX_CTRL, 32'h0000_1000);
      i_phy.frame_done();
      tx_try(1'b1, res, ticks);
      check("late collision retry", res, 1);
      check("late status on retry", 32'(tx_status_late), 32'h1);
      bus_rd(`MFR_IDX_STAT, rd);
      check("status attempts", {23'h0, rd[8:0]}, 32'h0000_0011);
      maxt = 0;
      for (int lim = 0; lim < 4; lim++) begin
         bus_wr(`MFR_IDX_STAT, 32'h0000_0003);
         bus_wr(`MFR_IDX_CTRL, {24'h0, lim[1:0], 6'h0});
         i_phy.frame_done();
         for (int n = 1; n <= 16; n++) begin
            tx_try(1'b0, res, ticks);
            k = (n < 10) ? n : 10;
            k = (k < bits_tab[lim]) ? k : bits_tab[lim];
            if (lim == 0 && ticks > maxt) maxt = ticks;
            if (n < 16) begin
               check("retry granted", res, 1);
               check("backoff bound", 32'(ticks <= (1 << k) + 1), 32'h1);
            end else begin
               check("retry exhausted", res, 2);
               check("retry error after attempts", 32'(tx_status_retry_err), 32'h1);
            end
         end
      end
      check("backoff varies", 32'(maxt > 2), 32'h1);
      close_out();
   end
endmodule : mfr_tb_top
`default_nettype wire
